// *** design/uit_int_timing.sv ***
// Transmit buffer, interrupt timing and APB registers of the serial port
//
// Behaviour
// - No FIFO: transmit interrupt when buffer word moves to shift register.
// - No FIFO: writing the next word clears the transmit interrupt.
// - Writing one to tx_int_clear_bit clears the transmit interrupt.
// - No FIFO: after software clear, write during stop bit suppresses that interrupt.
// - FIFO on: transmit interrupt when fill equals selected level.
// - Level select 000 means four entries, one eighth full.
// - FIFO on: cleared above level, raised again on draining back.
// - Overrun flagged after stop bit of a word that cannot be stored.
// - Parity error flagged right after parity bit is sampled.
// - Framing error flagged right after a bad stop bit position.
// - Receive timeout after 511 baud_x16_tick since data stored.
// - Receive interrupt and break flagged after the stop bit.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module uit_int_timing import uit_pkg::*; #(
  parameter int DEPTH = 32,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Transmit shifter
  output logic [DATA_W-1:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_TAKE,
  input wire logic TX_STOP,
  input wire logic TX_BUSY,
  // Receive engine
  input wire uit_rx_ev_s RX_EV,
  input wire logic RX_STORE,
  input wire logic RX_NONEMPTY,
  input wire logic BAUD_X16_TICK,
  // Interrupt
  output logic IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 8 || DEPTH % 8 != 0 || DATA_W < 1 || DATA_W > 32) begin : g_chk
    $error("uit_int_timing: DEPTH must be a multiple of 8, DATA_W 1..32");
  end

  // Fill level picked by tx_level_select_field
  function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
    logic [CW-1:0] e;
    e = CW'(DEPTH / 8);
    unique case (sel)
      3'h1: level_of = CW'(2 * e);
      3'h2: level_of = CW'(4 * e);
      3'h3: level_of = CW'(6 * e);
      3'h4: level_of = CW'(7 * e);
      default: level_of = e;
    endcase
  endfunction

  // Pointer advance with wrap at DEPTH
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // State
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic fifo_en_q, fifo_en_d;
  logic [2:0] lvl_sel_q, lvl_sel_d;
  uit_irq_t ris_q, ris_d, mask_q, mask_d;
  logic swclr_q, swclr_d, supp_q, supp_d;
  logic [31:0] prdata_q, prdata_d;

  // Decoded strokes
  logic acc, wr, rd_setup, mapped;
  logic push, pop, supp_hit, supp_eff;
  logic [CW-1:0] cap, lvl;
  uit_irq_t icr, set, clr;
  logic to_fire;

  // Zero-wait slave: read data is latched in the setup cycle
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_ICR);
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign PRDATA = prdata_q;

  // Transmit buffer strokes; one entry when the FIFO is off
  assign cap = fifo_en_q ? CW'(DEPTH) : CW'(1);
  assign lvl = level_of(lvl_sel_q);
  assign push = wr && PADDR == OFS_DATA && cnt_q < cap;
  assign pop = TX_TAKE && cnt_q != '0;
  assign TX_VALID = cnt_q != '0;
  assign TX_DATA = mem_q[rp_q];

  // Write racing the stop bit after a software clear loses its interrupt
  assign supp_hit = !fifo_en_q && swclr_q && push && TX_STOP;
  assign supp_eff = supp_q || supp_hit;

  assign icr = (wr && PADDR == OFS_ICR) ? PWDATA[NIRQ-1:0] : '0;

  // Receive timeout counter
  uit_rx_timeout #(
    .TICKS(RX_TIMEOUT_TICKS)
  ) u_timeout (
    .clk(SYS_CLK),
    .srst(SRST),
    .store(RX_STORE),
    .nonempty(RX_NONEMPTY),
    .tick(BAUD_X16_TICK),
    .fire(to_fire)
  );

  // Buffer pointers and fill count
  always_comb begin
    wp_d = push ? next_ptr(wp_q) : wp_q;
    rp_d = pop ? next_ptr(rp_q) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem_q[wp_q] <= PWDATA[DATA_W-1:0];
    end
  end

  // Interrupt event sources
  always_comb begin
    set = '0;
    clr = icr;
    set[IB_TX] = (!fifo_en_q && pop && !supp_eff)
      || (fifo_en_q && cnt_d == lvl && cnt_q != lvl);
    clr[IB_TX] = icr[IB_TX]
      || (!fifo_en_q && push)
      || (fifo_en_q && cnt_d > lvl);
    set[IB_RX] = RX_EV.stop_done;
    set[IB_BE] = RX_EV.stop_done && RX_EV.brk;
    set[IB_OE] = RX_EV.stop_done && RX_EV.fifo_full;
    set[IB_FE] = RX_EV.stop_done && !RX_EV.stop_ok;
    set[IB_PE] = RX_EV.parity_done && RX_EV.parity_bad;
    set[IB_TO] = to_fire;
  end

  // Control, status and the clear-suppress tracking
  always_comb begin
    fifo_en_d = fifo_en_q;
    lvl_sel_d = lvl_sel_q;
    mask_d = mask_q;
    // Set wins over any clear in the same cycle
    ris_d = (ris_q & ~clr) | set;
    // Clear seen mid-transmission arms the race; idle line disarms it
    swclr_d = TX_BUSY && (swclr_q || icr[IB_TX]);
    supp_d = pop ? 1'b0 : supp_eff;
    if (wr && PADDR == OFS_CTRL) begin
      fifo_en_d = PWDATA[CTRL_FIFO_EN];
    end
    if (wr && PADDR == OFS_LVL) begin
      lvl_sel_d = PWDATA[2:0];
    end
    if (wr && PADDR == OFS_MASK) begin
      mask_d = PWDATA[NIRQ-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      fifo_en_q <= CTRL_RST;
      lvl_sel_q <= LVL_RST;
      mask_q <= MASK_RST;
      ris_q <= '0;
      swclr_q <= 1'b0;
      supp_q <= 1'b0;
    end else begin
      fifo_en_q <= fifo_en_d;
      lvl_sel_q <= lvl_sel_d;
      mask_q <= mask_d;
      ris_q <= ris_d;
      swclr_q <= swclr_d;
      supp_q <= supp_d;
    end
  end

  // Level interrupt from registered status and mask
  assign IRQ = |(ris_q & mask_q);

  // Read mux, sampled in the setup cycle
  always_comb begin
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = '0;
      unique case (PADDR)
        OFS_CTRL: prdata_d[CTRL_FIFO_EN] = fifo_en_q;
        OFS_LVL: prdata_d[2:0] = lvl_sel_q;
        OFS_FLAG: begin
          prdata_d[FLAG_BUSY] = TX_BUSY;
          prdata_d[FLAG_TXFULL] = cnt_q >= cap;
          prdata_d[FLAG_TXEMPTY] = cnt_q == '0;
          prdata_d[FLAG_RXNE] = RX_NONEMPTY;
          prdata_d[FLAG_CNT_LSB +: CW] = cnt_q;
        end
        OFS_RIS: prdata_d[NIRQ-1:0] = ris_q;
        OFS_MASK: prdata_d[NIRQ-1:0] = mask_q;
        OFS_MIS: prdata_d[NIRQ-1:0] = ris_q & mask_q;
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  a_tx_buf_empty: assert property (
    !fifo_en_q && pop && !supp_eff |=> ris_q[IB_TX])
    else $error("tx interrupt missing after buffer emptied");
  a_tx_auto_clear: assert property (
    !fifo_en_q && push && !pop |=> !ris_q[IB_TX])
    else $error("tx interrupt not cleared by buffer write");
  a_tx_sw_clear: assert property (
    icr[IB_TX] && !set[IB_TX] |=> !ris_q[IB_TX])
    else $error("tx interrupt not cleared by clear bit");
  a_tx_race_lost: assert property (
    !fifo_en_q && pop && supp_eff && !ris_q[IB_TX] |=> !ris_q[IB_TX])
    else $error("tx interrupt raised despite clear race");
  a_tx_fifo_level: assert property (
    fifo_en_q && cnt_d == lvl && cnt_q != lvl |=> ris_q[IB_TX])
    else $error("tx interrupt missing at fifo level");
  a_tx_level_four: assert property (
    fifo_en_q && lvl_sel_q == 3'h0 && cnt_q == CW'(3) && push && !pop
    |=> cnt_q == CW'(4) && ris_q[IB_TX])
    else $error("level 000 did not fire at four entries");
  a_tx_above_lvl: assert property (
    fifo_en_q && $past(fifo_en_q) && $stable(lvl_sel_q) && cnt_q > lvl
    |-> !ris_q[IB_TX])
    else $error("tx interrupt held above fifo level");
  a_rx_overrun: assert property (
    RX_EV.stop_done && RX_EV.fifo_full |=> ris_q[IB_OE] && ris_q[IB_RX])
    else $error("overrun not flagged after stop bit");
  a_rx_parity: assert property (
    RX_EV.parity_done && RX_EV.parity_bad |=> ris_q[IB_PE])
    else $error("parity error not flagged");
  a_rx_framing: assert property (
    RX_EV.stop_done && !RX_EV.stop_ok |=> ris_q[IB_FE])
    else $error("framing error not flagged");
  a_rx_timeout: assert property (
    to_fire |=> ris_q[IB_TO])
    else $error("receive timeout not flagged");
  a_rx_stop_int: assert property (
    RX_EV.stop_done && RX_EV.brk |=> ris_q[IB_RX] && ris_q[IB_BE])
    else $error("receive or break not flagged after stop bit");

  c_tx_single: cover property (!fifo_en_q && pop ##1 push);
  c_tx_race: cover property (supp_hit);
  c_tx_level: cover property (fifo_en_q && set[IB_TX]);
  c_rx_timeout: cover property (to_fire);
endmodule

// *** design/uit_rx_timeout.sv ***
// Receive timeout counter on the sixteen-times baud tick
`timescale 1ns/100ps
module uit_rx_timeout import uit_pkg::*; #(
  parameter int TICKS = RX_TIMEOUT_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Receive FIFO state and baud tick
  input wire logic store,
  input wire logic nonempty,
  input wire logic tick,
  // Timeout event
  output logic fire
);
  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic armed_q, armed_d;

  if (TICKS < 2) begin : g_chk
    $error("uit_rx_timeout: TICKS must be at least 2");
  end

  // Fires once per idle stretch after the last stored word
  assign fire = armed_q && tick && (cnt_q == CW'(TICKS - 1));

  // New data restarts the count; an empty FIFO stops it
  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    if (store) begin
      cnt_d = '0;
      armed_d = 1'b1;
    end else if (!nonempty || fire) begin
      cnt_d = '0;
      armed_d = 1'b0;
    end else if (armed_q && tick) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  // Count registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_to_restart: assert property (store |=> cnt_q == '0 && armed_q)
    else $error("timeout count did not restart on store");
  a_to_span: assert property (fire |-> $past(armed_q) && cnt_q != '0)
    else $error("timeout fired without a running count");
endmodule

// *** pkg/uit_pkg.sv ***
// Shared constants and types for the serial interrupt timing block
package uit_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_LVL = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0c;
  localparam logic [7:0] OFS_RIS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_MIS = 8'h18;
  localparam logic [7:0] OFS_ICR = 8'h1c;
  // Interrupt bit positions, shared by raw, mask, masked and clear
  localparam int IB_TX = 0;
  localparam int IB_RX = 1;
  localparam int IB_TO = 2;
  localparam int IB_PE = 3;
  localparam int IB_FE = 4;
  localparam int IB_BE = 5;
  localparam int IB_OE = 6;
  localparam int NIRQ = 7;
  // Control and flag fields
  localparam int CTRL_FIFO_EN = 0;
  localparam int FLAG_BUSY = 0;
  localparam int FLAG_TXFULL = 1;
  localparam int FLAG_TXEMPTY = 2;
  localparam int FLAG_RXNE = 3;
  localparam int FLAG_CNT_LSB = 8;
  // Reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [NIRQ-1:0] MASK_RST = 7'h00;
  // Receive timeout in sixteen-times baud ticks
  localparam int RX_TIMEOUT_TICKS = 511;
  // Interrupt vector type
  typedef logic [NIRQ-1:0] uit_irq_t;
  // Receive engine events, all one-cycle pulses except the levels
  typedef struct packed {
    logic parity_done;
    logic parity_bad;
    logic stop_done;
    logic stop_ok;
    logic brk;
    logic fifo_full;
  } uit_rx_ev_s;
endpackage

// *** sim/tb_uit_int_timing.sv ***
// Self-checking bench for the serial interrupt timing block
`timescale 1ns/100ps
module tb_uit_int_timing import uit_pkg::*;;
  logic SYS_CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, err, TX_VALID, TX_TAKE, TX_STOP, TX_BUSY, IRQ;
  logic [7:0] TX_DATA;
  logic hold = 1, RX_STORE = 0, RX_NONEMPTY = 0, BAUD_X16_TICK = 0;
  uit_rx_ev_s RX_EV = '0;
  logic [5:0] ev [5] = '{6'h0c, 6'h0e, 6'h0d, 6'h08, 6'h30};
  logic [6:0] ex [5] = '{7'h02, 7'h22, 7'h42, 7'h12, 7'h08};
  int fails = 0, n_checks = 0;
  int cyc = 0, t0 = 0;
  // Frame length of the shifter model in clock cycles
  localparam int FRAME = 40;
  always #12.5 SYS_CLK = ~SYS_CLK;
  // Edge counter, lets a write be aimed at the stop bit
  always @(posedge SYS_CLK) cyc <= cyc + 1;
  uit_int_timing i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_TAKE(TX_TAKE),
    .TX_STOP(TX_STOP), .TX_BUSY(TX_BUSY), .RX_EV(RX_EV),
    .RX_STORE(RX_STORE), .RX_NONEMPTY(RX_NONEMPTY),
    .BAUD_X16_TICK(BAUD_X16_TICK), .IRQ(IRQ));
  uit_shift_model #(.BITS(FRAME)) i_shift (.clk(SYS_CLK), .srst(SRST),
    .hold(hold),
    .tx_valid(TX_VALID), .tx_take(TX_TAKE), .tx_stop(TX_STOP),
    .tx_busy(TX_BUSY));
  // Verdict and end of run
  task results;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge SYS_CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge SYS_CLK);
      if (PREADY === 1'b1) break;
    end
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (i == 20) begin
      fails++;
      results();
    end
  endtask
  task ris(input logic [31:0] e);
    xfer(0, OFS_RIS, 32'h0);
    chk("ris", e, q);
  endtask
  // Polls the raw transmit bit; gives up after a bounded count
  task wait_tx;
    int k;
    for (k = 0; k < 60; k++) begin
      xfer(0, OFS_RIS, 32'h0);
      if (q[IB_TX] === 1'b1) break;
    end
    chk("tx set", 32'h1, 32'(q[IB_TX]));
  endtask
  // Waits for the shifter to take a word; notes the edge count then
  task wait_take;
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge SYS_CLK);
      if (TX_TAKE === 1'b1) break;
    end
    t0 = cyc;
    chk("take", 32'h1, 32'(TX_TAKE));
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge SYS_CLK);
      BAUD_X16_TICK <= 1;
      @(posedge SYS_CLK);
      BAUD_X16_TICK <= 0;
    end
  endtask
  task store;
    @(posedge SYS_CLK);
    RX_STORE <= 1;
    RX_NONEMPTY <= 1;
    @(posedge SYS_CLK);
    RX_STORE <= 0;
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK);
    SRST <= 0;
    // Mask reset value and an unmapped offset
    xfer(0, OFS_MASK, 32'h0);
    chk("mask", 32'(MASK_RST), q);
    xfer(1, 8'h20, 32'h1);
    chk("slverr", 32'h1, 32'(err));
    $display("test reset done");
    // Single buffer: pop, auto clear by next write, software clear
    xfer(1, OFS_MASK, 32'h1);
    xfer(1, OFS_DATA, 32'h5a);
    xfer(0, OFS_FLAG, 32'h0);
    chk("flag", 32'h102, q);
    ris(32'h0);
    chk("txdata", 32'h5a, 32'(TX_DATA));
    hold <= 0;
    wait_tx();
    @(negedge SYS_CLK);
    chk("irq", 32'h1, 32'(IRQ));
    xfer(0, OFS_MIS, 32'h0);
    chk("mis", 32'h1, q);
    xfer(1, OFS_DATA, 32'ha5);
    ris(32'h0);
    wait_tx();
    xfer(1, OFS_ICR, 32'h1);
    ris(32'h0);
    @(negedge SYS_CLK);
    chk("irq", 32'h0, 32'(IRQ));
    $display("test single buffer done");
    // Clear mid-frame, then a write on the stop bit loses the interrupt
    xfer(1, OFS_DATA, 32'h3c);
    wait_take();
    xfer(1, OFS_ICR, 32'h1);
    ris(32'h0);
    // Zero-wait slave: the write lands three edges after the call
    for (int k = 0; k < 100 && cyc != t0 + FRAME - 3; k++) begin
      @(posedge SYS_CLK);
    end
    xfer(1, OFS_DATA, 32'hc3);
    chk("stop", 32'h1, 32'(TX_STOP));
    ris(32'h0);
    $display("test clear race done");
    // FIFO mode at level code 000, four entries
    xfer(1, OFS_CTRL, 32'h1);
    hold <= 1;
    xfer(1, OFS_LVL, 32'h1);
    xfer(0, OFS_LVL, 32'h0);
    chk("lvl", 32'h1, q);
    xfer(1, OFS_LVL, 32'h0);
    repeat (3) xfer(1, OFS_DATA, 32'h11);
    ris(32'h0);
    xfer(1, OFS_DATA, 32'h22);
    ris(32'h1);
    xfer(1, OFS_DATA, 32'h33);
    ris(32'h0);
    hold <= 0;
    wait_tx();
    $display("test fifo level done");
    // Receive events, one per table row
    xfer(1, OFS_ICR, 32'h7f);
    for (int j = 0; j < 5; j++) begin
      @(posedge SYS_CLK);
      RX_EV <= uit_rx_ev_s'(ev[j]);
      @(posedge SYS_CLK);
      RX_EV <= '0;
      ris(32'(ex[j]));
      xfer(1, OFS_ICR, 32'h7f);
    end
    $display("test receive events done");
    // Timeout restarts on a new store, then fires at 511
    store();
    ticks(300);
    store();
    ticks(510);
    ris(32'h0);
    ticks(1);
    ris(32'h1 << IB_TO);
    $display("test timeout done");
    $display("checks %0d mismatches %0d", n_checks, fails);
    results();
  end
endmodule

// *** sim/uit_shift_model.sv ***
// Transmit shifter model that takes words and frames them
`timescale 1ns/100ps
module uit_shift_model #(
  parameter int BITS = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Stall request and buffer state
  input wire logic hold,
  input wire logic tx_valid,
  // Shifter events
  output logic tx_take,
  output logic tx_stop,
  output logic tx_busy
);
  int cnt_q;
  int cnt_d;
  // Next frame only starts when idle, never mid-frame
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q > 0) cnt_d = cnt_q - 1;
    else if (tx_take) cnt_d = BITS;
  end
  always_ff @(posedge clk) begin
    cnt_q <= srst ? 0 : cnt_d;
  end
  // Pop pulse, stop pulse on the last bit, busy level
  assign tx_take = !srst && cnt_q == 0 && tx_valid === 1'b1 && !hold;
  assign tx_stop = cnt_q == 1;
  assign tx_busy = cnt_q > 0;
endmodule
